//--- ihc_capture.sv
// Behaviour
// - Control bit 6 keeps home capture until read
// - Control bit 8 enables high-speed capture
// - Control bit 9 keeps held high-speed capture
// - Control bit 10 latches high-speed capture
// - Control bit 12 zeroes position on index
// - Control bit 13 resets phase on index
// - First index stores phase, later ones load
// - Status bit 0 index captured, read clears
// - Status bit 3 index overrun while held
// - Status bit 4 home captured, read clears
// - Status bit 7 home overrun while held
// - Status bit 8 new high-speed data
// - Status bit 11 high-speed overflow
// - Control bits 0/1 select index edges
// - Control bit 2 keeps index capture
// - Control bit 5 selects home edge
// - Index position read clears bits 0, 3
`timescale 1ns/1ps
`default_nettype none
module ihc_capture
   import ihc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Capture pins, active high
   input wire logic index_in,
   input wire logic home_in,
   input wire logic hs_in,
   // Position and phase from the drive
   input wire logic [31:0] pos_count,
   input wire logic [15:0] phase_angle,
   input wire logic phase_ok,
   // Parameter port
   input wire logic par_wr,
   input wire logic par_rd,
   input wire logic [8:0] par_id,
   input wire logic [15:0] par_wdata,
   output logic [31:0] par_rdata,
   output logic par_rvalid,
   // Actions on the drive
   output logic pos_clear,
   output logic phase_load,
   output logic [15:0] phase_value
);
   ////////////////////////////////////////////////////////////////////////////////
   ihc_edge_if edges ();
   logic [15:0] ctl_q;
   logic [15:0] stat_q;
   ihc_pos_t idx_pos_q;
   ihc_pos_t home_pos_q;
   ihc_pos_t hs_pos_q;
   logic [15:0] ph_store_q;
   logic ph_armed_q;
   logic [31:0] rdata_q;
   logic rvalid_q;
   logic pos_clear_q;
   logic phase_load_q;
   logic [15:0] phase_value_q;
   logic idx_ev;
   logic home_ev;
   logic hs_ev;
   logic rd_idx;
   logic rd_home;
   logic rd_hs;
   logic hs_keep;

   // A new capture may replace the held one unless keep is asked for
   function automatic logic may_write(input logic held, input logic keep);
      may_write = !(held && keep);
   endfunction

   ihc_edge_sync ihc_edge_sync_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_raw({hs_in, home_in, index_in}),
      .edges(edges)
   );

   ////////////////////////////////////////////////////////////////////////////////
   assign idx_ev = (ctl_q[C_IDX_RISE] && edges.rise[L_IDX])
      || (ctl_q[C_IDX_FALL] && edges.fall[L_IDX]);
   // Home switch is active high: release is the falling edge
   assign home_ev = ctl_q[C_HOME_EDGE] ? edges.fall[L_HOME] : edges.rise[L_HOME];
   assign hs_ev = ctl_q[C_HS_EN] && edges.rise[L_HS];
   assign hs_keep = ctl_q[C_HS_NOOVR] || ctl_q[C_HS_LATCH];
   assign rd_idx = par_rd && (par_id == ID_IDX_POS);
   assign rd_home = par_rd && (par_id == ID_HOME_POS);
   assign rd_hs = par_rd && (par_id == ID_HS_POS);

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         ctl_q <= CTL_RESET;
      else if (par_wr && (par_id == ID_CTL))
         ctl_q <= par_wdata & CTL_MASK;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Captured positions, taken in the cycle the edge is seen
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         idx_pos_q <= '0;
         home_pos_q <= '0;
         hs_pos_q <= '0;
      end
      else
      begin
         if (idx_ev && may_write(stat_q[S_IDX], ctl_q[C_IDX_KEEP]))
            idx_pos_q <= pos_count;
         if (home_ev && may_write(stat_q[S_HOME], ctl_q[C_HOME_KEEP]))
            home_pos_q <= pos_count;
         if (hs_ev && may_write(stat_q[S_HS], hs_keep))
            hs_pos_q <= pos_count;
      end
   end

   // Status: a capture in the read cycle wins over the clear
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         stat_q <= STAT_RESET;
      else
      begin
         if (idx_ev)
            stat_q[S_IDX] <= 1'b1;
         else if (rd_idx)
            stat_q[S_IDX] <= 1'b0;
         if (idx_ev && stat_q[S_IDX])
            stat_q[S_IDX_OVR] <= 1'b1;
         else if (rd_idx)
            stat_q[S_IDX_OVR] <= 1'b0;
         if (home_ev)
            stat_q[S_HOME] <= 1'b1;
         else if (rd_home)
            stat_q[S_HOME] <= 1'b0;
         if (home_ev && stat_q[S_HOME])
            stat_q[S_HOME_OVR] <= 1'b1;
         else if (rd_home)
            stat_q[S_HOME_OVR] <= 1'b0;
         if (hs_ev)
            stat_q[S_HS] <= 1'b1;
         else if (rd_hs)
            stat_q[S_HS] <= 1'b0;
         if (hs_ev && stat_q[S_HS])
            stat_q[S_HS_OVR] <= 1'b1;
         else if (rd_hs)
            stat_q[S_HS_OVR] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Position clear follows every index rising edge, not the capture edge choice
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         pos_clear_q <= 1'b0;
      else
         pos_clear_q <= ctl_q[C_POS_CLR] && edges.rise[L_IDX];
   end

   // Phase reference; disarming on bit 13 clear makes the next enable re-store
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ph_armed_q <= 1'b0;
         ph_store_q <= '0;
         phase_load_q <= 1'b0;
         phase_value_q <= '0;
      end
      else
      begin
         phase_load_q <= 1'b0;
         if (!ctl_q[C_PH_RST])
            ph_armed_q <= 1'b0;
         else if (idx_ev && phase_ok)
         begin
            if (!ph_armed_q)
            begin
               ph_store_q <= phase_angle;
               ph_armed_q <= 1'b1;
            end
            else
            begin
               phase_load_q <= 1'b1;
               phase_value_q <= ph_store_q;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data registered; unknown identifiers read zero
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= par_rd;
         if (par_rd)
         begin
            unique case (par_id)
               ID_CTL: rdata_q <= {16'h0000, ctl_q};
               ID_STAT: rdata_q <= {16'h0000, stat_q};
               ID_IDX_POS: rdata_q <= idx_pos_q;
               ID_HOME_POS: rdata_q <= home_pos_q;
               ID_HS_POS: rdata_q <= hs_pos_q;
               default: rdata_q <= '0;
            endcase
         end
      end
   end

   assign par_rdata = rdata_q;
   assign par_rvalid = rvalid_q;
   assign pos_clear = pos_clear_q;
   assign phase_load = phase_load_q;
   assign phase_value = phase_value_q;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Status bits that carry a flag; every other bit is reserved
   localparam logic [15:0] STAT_USED = (16'h0001 << S_IDX) | (16'h0001 << S_IDX_OVR)
      | (16'h0001 << S_HOME) | (16'h0001 << S_HOME_OVR)
      | (16'h0001 << S_HS) | (16'h0001 << S_HS_OVR);

   a_home_keep_held: assert property (
      home_ev && stat_q[S_HOME] && ctl_q[C_HOME_KEEP] |=> $stable(home_pos_q))
      else $error("home capture overwritten");
   a_hs_disabled: assert property (
      !ctl_q[C_HS_EN] |=> $stable(hs_pos_q))
      else $error("high-speed capture while off");
   a_hs_noovr_held: assert property (
      hs_ev && stat_q[S_HS] && ctl_q[C_HS_NOOVR] |=> $stable(hs_pos_q))
      else $error("high-speed capture overwritten");
   a_hs_latch_held: assert property (
      hs_ev && stat_q[S_HS] && ctl_q[C_HS_LATCH] |=> $stable(hs_pos_q))
      else $error("latched capture overwritten");
   a_pos_clear_pulse: assert property (
      ctl_q[C_POS_CLR] && edges.rise[L_IDX] |=> pos_clear)
      else $error("position clear missing");
   a_phase_load_src: assert property (
      phase_load |-> $past(idx_ev) && $past(ph_armed_q) && phase_value == ph_store_q)
      else $error("phase load without cause");
   a_phase_first_store: assert property (
      idx_ev && phase_ok && ctl_q[C_PH_RST] && !ph_armed_q |=> !phase_load && ph_armed_q)
      else $error("first index did not store");
   a_idx_flag_set: assert property (
      idx_ev |=> stat_q[S_IDX] && idx_pos_q == $past(pos_count)
      || $past(stat_q[S_IDX] && ctl_q[C_IDX_KEEP]))
      else $error("index not captured");
   a_idx_read_clr: assert property (
      rd_idx && !idx_ev |=> !stat_q[S_IDX] && !stat_q[S_IDX_OVR])
      else $error("index read did not clear");
   a_idx_overrun: assert property (
      idx_ev && stat_q[S_IDX] |=> stat_q[S_IDX_OVR])
      else $error("index overrun not flagged");
   a_home_overrun: assert property (
      home_ev && stat_q[S_HOME] |=> stat_q[S_HOME_OVR])
      else $error("home overrun not flagged");
   a_hs_overflow: assert property (
      hs_ev && stat_q[S_HS] |=> stat_q[S_HS_OVR])
      else $error("overflow not flagged");
   a_reserved_zero: assert property (
      (ctl_q & ~CTL_MASK) == 16'h0000 && (stat_q & ~STAT_USED) == 16'h0000)
      else $error("reserved bit set");

   c_idx_capture: cover property (idx_ev ##[1:20] rd_idx);
   c_home_overrun: cover property (home_ev && stat_q[S_HOME]);
   c_hs_overflow: cover property (hs_ev && stat_q[S_HS] && ctl_q[C_HS_LATCH]);
   c_phase_reload: cover property (phase_load);
endmodule // ihc_capture
`default_nettype wire

//--- ihc_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ihc_edge_if;
   logic [2:0] rise;
   logic [2:0] fall;
   modport src (output rise, output fall);
   modport dst (input rise, input fall);
endinterface
`default_nettype wire

//--- ihc_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ihc_edge_sync
   import ihc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Raw pins
   input wire logic [LANES-1:0] pin_raw,
   // Edges
   ihc_edge_if.src edges
);
   logic [LANES-1:0] meta_q;
   logic [LANES-1:0] sync_q;
   logic [LANES-1:0] prev_q;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end
      else
      begin
         meta_q <= pin_raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign edges.rise = sync_q & ~prev_q;
   assign edges.fall = ~sync_q & prev_q;
endmodule // ihc_edge_sync
`default_nettype wire

//--- ihc_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module ihc_pins_model
(
   // Clock
   input wire logic clk,
   // Pins and drive state
   output logic index_in,
   output logic home_in,
   output logic hs_in,
   output logic [31:0] pos_count,
   output logic [15:0] phase_angle,
   output logic phase_ok
);
   initial
   begin
      {index_in, home_in, hs_in} = 3'h0;
      pos_count = 32'h0;
      phase_angle = 16'h0;
      phase_ok = 1'b1;
   end
   // Position is held for the whole window so the sync delay cannot miss it
   task automatic set(input int lane, input logic lvl, input logic [31:0] pos);
      @(negedge clk);
      pos_count = pos;
      phase_angle = pos[15:0];
      case (lane)
         0: index_in = lvl;
         1: home_in = lvl;
         default: hs_in = lvl;
      endcase
      repeat (6) @(negedge clk);
   endtask
   // Phase reference is only usable in some commutation set-ups
   task automatic set_ok(input logic ok);
      @(negedge clk);
      phase_ok = ok;
   endtask
endmodule // ihc_pins_model
`default_nettype wire

//--- ihc_pkg.sv
`default_nettype none
package ihc_pkg;
   // Parameter identifiers on the drive's parameter port
   localparam logic [8:0] ID_IDX_POS = 9'h068;
   localparam logic [8:0] ID_CTL = 9'h06c;
   localparam logic [8:0] ID_STAT = 9'h06d;
   localparam logic [8:0] ID_HOME_POS = 9'h10a;
   localparam logic [8:0] ID_HS_POS = 9'h111;
   // Capture control fields
   localparam int C_IDX_RISE = 0;
   localparam int C_IDX_FALL = 1;
   localparam int C_IDX_KEEP = 2;
   localparam int C_HOME_EDGE = 5;
   localparam int C_HOME_KEEP = 6;
   localparam int C_HS_EN = 8;
   localparam int C_HS_NOOVR = 9;
   localparam int C_HS_LATCH = 10;
   localparam int C_POS_CLR = 12;
   localparam int C_PH_RST = 13;
   localparam logic [15:0] CTL_MASK = 16'h3767;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   // Capture status fields
   localparam int S_IDX = 0;
   localparam int S_IDX_OVR = 3;
   localparam int S_HOME = 4;
   localparam int S_HOME_OVR = 7;
   localparam int S_HS = 8;
   localparam int S_HS_OVR = 11;
   localparam logic [15:0] STAT_RESET = 16'h0000;
   // Capture input lanes
   localparam int L_IDX = 0;
   localparam int L_HOME = 1;
   localparam int L_HS = 2;
   localparam int LANES = 3;
   typedef logic [31:0] ihc_pos_t;
endpackage
`default_nettype wire

//--- index_home_position_capture_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module index_home_position_capture_tb
   import ihc_pkg::*;
   ;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic par_wr = 1'b0;
   logic par_rd = 1'b0;
   logic [8:0] par_id = 9'h000;
   logic [15:0] par_wdata = 16'h0000;
   logic [31:0] par_rdata;
   logic par_rvalid, pos_clear, phase_load, index_in, home_in, hs_in, phase_ok;
   logic [15:0] phase_value, phase_angle, ph;
   logic [31:0] pos_count;
   int n_fail = 0;
   int samples_checked = 0;
   int n_clr = 0;
   int n_load = 0;
   always #5 clk = ~clk;
   ihc_pins_model model (.clk(clk), .index_in(index_in), .home_in(home_in), .hs_in(hs_in),
      .pos_count(pos_count), .phase_angle(phase_angle), .phase_ok(phase_ok));
   ihc_capture ihc_capture_inst (.clk(clk), .sys_rst(sys_rst), .index_in(index_in),
      .home_in(home_in), .hs_in(hs_in), .pos_count(pos_count), .phase_angle(phase_angle),
      .phase_ok(phase_ok), .par_wr(par_wr), .par_rd(par_rd), .par_id(par_id),
      .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rvalid(par_rvalid),
      .pos_clear(pos_clear), .phase_load(phase_load), .phase_value(phase_value));
   // Pulses are counted mid-cycle, where they are settled
   always @(negedge clk)
   begin
      if (pos_clear === 1'b1)
         n_clr++;
      if (phase_load === 1'b1)
      begin
         n_load++;
         ph = phase_value;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [8:0] id, input logic [15:0] d);
      @(negedge clk);
      par_wr = 1'b1;
      par_id = id;
      par_wdata = d;
      @(negedge clk);
      par_wr = 1'b0;
      `CHK("rvalid", 1'b0, par_rvalid)
   endtask
   // Read data is checked half a cycle after the taking edge
   task automatic chk(input logic [8:0] id, input logic [31:0] e);
      @(negedge clk);
      par_rd = 1'b1;
      par_id = id;
      @(negedge clk);
      par_rd = 1'b0;
      `CHK("rvalid", 1'b1, par_rvalid)
      `CHK($sformatf("id %h", id), e, par_rdata)
   endtask
   task automatic t_regs;
      chk(ID_CTL, 32'h0);
      chk(ID_STAT, 32'h0);
      wr(ID_CTL, 16'hffff);
      chk(ID_CTL, 32'h00003767);
      chk(9'h000, 32'h0);
      $display("t_regs done");
   endtask
   task automatic t_index;
      wr(ID_CTL, 16'h0005);
      model.set(0, 1, 32'h11110001);
      chk(ID_STAT, 32'h1);
      model.set(0, 0, 32'h2);
      chk(ID_STAT, 32'h1);
      model.set(0, 1, 32'h3);
      chk(ID_STAT, 32'h9);
      chk(ID_IDX_POS, 32'h11110001);
      chk(ID_STAT, 32'h0);
      wr(ID_CTL, 16'h0002);
      model.set(0, 0, 32'h4);
      model.set(0, 1, 32'h5);
      model.set(0, 0, 32'h6);
      chk(ID_STAT, 32'h9);
      chk(ID_IDX_POS, 32'h6);
      $display("t_index done");
   endtask
   task automatic t_home;
      wr(ID_CTL, 16'h0040);
      model.set(1, 1, 32'h10);
      chk(ID_STAT, 32'h10);
      model.set(1, 0, 32'h11);
      model.set(1, 1, 32'h12);
      chk(ID_STAT, 32'h90);
      chk(ID_HOME_POS, 32'h10);
      chk(ID_STAT, 32'h0);
      wr(ID_CTL, 16'h0020);
      model.set(1, 0, 32'h13);
      model.set(1, 1, 32'h14);
      model.set(1, 0, 32'h15);
      chk(ID_HOME_POS, 32'h15);
      $display("t_home done");
   endtask
   task automatic t_hs;
      logic [15:0] cfg [3] = '{16'h0100, 16'h0300, 16'h0500};
      wr(ID_CTL, 16'h0000);
      model.set(2, 1, 32'h20);
      model.set(2, 0, 32'h20);
      chk(ID_STAT, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         wr(ID_CTL, cfg[i]);
         model.set(2, 1, 32'h31 + i);
         chk(ID_STAT, 32'h100);
         model.set(2, 0, 32'h0);
         model.set(2, 1, 32'h41 + i);
         model.set(2, 0, 32'h0);
         chk(ID_STAT, 32'h900);
         chk(ID_HS_POS, (i == 0) ? 32'h41 : 32'h31 + i);
      end
      $display("t_hs done");
   endtask
   task automatic t_phase;
      wr(ID_CTL, 16'h1001);
      n_clr = 0;
      model.set(0, 1, 32'h0);
      model.set(0, 0, 32'h0);
      model.set(0, 1, 32'h0);
      `CHK("pos_clear", 2, n_clr)
      model.set(0, 0, 32'h0);
      wr(ID_CTL, 16'h2001);
      n_load = 0;
      model.set(0, 1, 32'h0040);
      model.set(0, 0, 32'h0);
      `CHK("phase_load", 0, n_load)
      model.set(0, 1, 32'h0050);
      `CHK("phase_load", 1, n_load)
      `CHK("phase_value", 16'h0040, ph)
      model.set(0, 0, 32'h0);
      model.set_ok(1'b0);
      model.set(0, 1, 32'h0060);
      `CHK("phase_load", 1, n_load)
      model.set_ok(1'b1);
      model.set(0, 0, 32'h0);
      model.set(0, 1, 32'h0070);
      `CHK("phase_load", 2, n_load)
      `CHK("phase_value", 16'h0040, ph)
      $display("t_phase done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      t_regs();
      t_index();
      t_home();
      t_hs();
      t_phase();
      results();
   end
   // Whole run is near 340 cycles
   initial
   begin
      #100000;
      n_fail++;
      results();
   end
endmodule // index_home_position_capture_tb
`default_nettype wire
